// [shared/srr_pkg.sv]
// constants for the serial clock/calendar block with its scratch memory
// assumes a 10 MHz system clock and synchronous pin inputs
package srr_pkg;
    localparam int CLK_HZ = 10_000_000;
    // serial address map, six address bits
    localparam logic [5:0] RAM_LAST = 6'h1f;
    localparam logic [5:0] TIME_BASE = 6'h20;
    localparam logic [5:0] ALM_BASE = 6'h27;
    localparam logic [5:0] MAP_LAST = 6'h29;
    localparam int WR_BIT = 7;
    localparam int NUM_TIME = 7;
    localparam int NUM_ALM = 3;
    localparam int NUM_RAM = 32;
    // calendar field indexes
    localparam int R_SEC = 0;
    localparam int R_MIN = 1;
    localparam int R_HOUR = 2;
    localparam int R_DOW = 3;
    localparam int R_DATE = 4;
    localparam int R_MON = 5;
    localparam int R_YEAR = 6;
    localparam int HR_PM_BIT = 5;
    // reset values of the calendar fields
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONE = 8'h01;
    localparam logic [7:0] HR12_RST = 8'h12;
    // bcd limits
    localparam logic [7:0] MAX_SEC = 8'h59;
    localparam logic [7:0] MAX_HR24 = 8'h23;
    localparam logic [7:0] MAX_DOW = 8'h07;
    localparam logic [7:0] MAX_MON = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;
    // time base terminal counts
    localparam logic [15:0] LINE_50 = 16'h0032;
    localparam logic [15:0] LINE_60 = 16'h003c;
    localparam int XTAL_DIV = 32768;
    // interrupt flag positions
    localparam int F_ALM = 0;
    localparam int F_PER = 1;
    localparam int F_PWR = 2;
    // watchdog window and host reset pulse
    localparam int WDOG_MS = 10;
    localparam int WDOG_CYC = CLK_HZ / 1000 * WDOG_MS;
    localparam int HRST_US = 10;
    localparam int HRST_CYC = CLK_HZ / 1_000_000 * HRST_US;
    // write buffer shape: address and data byte
    localparam int FIFO_W = 14;
    localparam int FIFO_D = 16;
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_PDN = 2'b10
    } srr_st_t;
endpackage

// [rtl/srr_fifo.sv]
// small synchronous fifo holding serial writes until applied
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module srr_fifo #(
    parameter int W = 14,
    parameter int D = 16
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] rp;
        logic [AW-1:0] wp;
        logic [AW:0] cnt;
    } srr_fifo_st_t;
    srr_fifo_st_t s_ff;
    srr_fifo_st_t nxt_s;
    logic push;
    logic pop;

    generate
        if (D < 2 || (D & (D - 1)) != 0 || W < 1)
        begin : g_bad
            $error("fifo depth must be a power of two");
        end
    endgenerate

    // handshakes from the fill level
    assign in_ready_o = (s_ff.cnt != D[AW:0]);
    assign out_valid_o = (s_ff.cnt != '0);
    assign out_data_o = s_ff.mem[s_ff.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointer and count update
    always_comb
    begin
        nxt_s = s_ff;
        if (push)
        begin
            nxt_s.mem[s_ff.wp] = in_data_i;
            nxt_s.wp = s_ff.wp + 1'b1;
        end
        if (pop)
        begin
            nxt_s.rp = s_ff.rp + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_s.cnt = s_ff.cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end
endmodule

// [rtl/srr_top.sv]
// serial clock/calendar with scratch memory, alarm, power control
// assumes pins already synchronous to clock_i; three-state data out
`timescale 1ns/1ps
// Contract
// - thirty-two bytes of scratch memory reachable over the serial port
// - one start address, then each further byte advances the location
// - time base chosen between crystal input and 50/60 Hz line input
// - one interrupt output for alarm, periodic and power-sense events
// - alarm fires when seconds, minutes and hours match alarm values
// - with system power valid, alarm raises supply enable, starts power-up
// - setting the power-down control bit starts software power-down
// - power-down: host reset on, clock and supply low, serial ignored
// - leave power-down on power rising edge or new enabled interrupt while power is valid
// - missed toggle on enabled watchdog asserts host reset
// - calendar counts to year 99 in 12/24 hour form with leap years
// - all calendar values held and accepted in bcd
// - reset sets a first-time-up flag until time is written
// - reads return a frozen snapshot while timekeeping continues
// - buffered clock output derived from the time base
module srr_top #(
    parameter int XTAL_DIV = srr_pkg::XTAL_DIV,
    parameter int WDOG_CYC = srr_pkg::WDOG_CYC,
    parameter int HRST_CYC = srr_pkg::HRST_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic ss_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic xtal_i,
    input wire logic line_i,
    input wire logic line_sel_i,
    input wire logic line_60hz_i,
    input wire logic hour_12_i,
    input wire logic [2:0] int_en_i,
    input wire logic [1:0] per_rate_i,
    input wire logic [2:0] int_clear_i,
    input wire logic wdog_en_i,
    input wire logic power_down_i,
    input wire logic system_power_sense_i,
    output logic irq_o,
    output logic [2:0] int_flags_o,
    output logic host_reset_o,
    output logic supply_enable_o,
    output logic buffered_clock_o,
    output logic first_up_o,
    output logic wr_overrun_o
);
    typedef struct packed {
        srr_pkg::srr_st_t st;
        logic [srr_pkg::NUM_RAM-1:0][7:0] ram;
        logic [srr_pkg::NUM_TIME-1:0][7:0] tm;
        logic [srr_pkg::NUM_TIME-1:0][7:0] snap;
        logic [srr_pkg::NUM_ALM-1:0][7:0] alm;
        logic [15:0] div;
        logic base_q;
        logic sck_q;
        logic ss_q;
        logic sys_q;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [2:0] bitc;
        logic [5:0] addr;
        logic first;
        logic wr;
        logic miso;
        logic oe_n;
        logic [2:0] flags;
        logic irq;
        logic [19:0] wdog;
        logic [7:0] hrst;
        logic hreset;
        logic supply;
        logic clk_out;
        logic first_up;
        logic overrun;
    } srr_st_t;

    srr_st_t s_ff;
    srr_st_t nxt_s;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [srr_pkg::FIFO_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [srr_pkg::FIFO_W-1:0] fifo_out_data;

    generate
        if (XTAL_DIV < 2 || XTAL_DIV > 65535 || WDOG_CYC < 2 ||
            WDOG_CYC > 1048575 || HRST_CYC < 1 || HRST_CYC > 255)
        begin : g_bad
            $error("count parameter out of range");
        end
    endgenerate

    // bcd increment with wrap; returns carry and next value
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
        input logic [7:0] lo, input logic [7:0] hi);
        if (v >= hi)
        begin
            bcd_inc = {1'b1, lo};
        end
        else if (v[3:0] >= 4'h9)
        begin
            bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // last date of a month, february from a bcd year
    function automatic logic [7:0] month_end(input logic [7:0] mon,
        input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                        yr[3:0] == 4'h8);
        case (mon)
            8'h02: month_end = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    endfunction

    // serial read data: memory, frozen calendar, alarm, else zero
    function automatic logic [7:0] rd_byte(input srr_st_t s,
        input logic [5:0] a);
        if (a <= srr_pkg::RAM_LAST)
        begin
            rd_byte = s.ram[a[4:0]];
        end
        else if (a < srr_pkg::ALM_BASE)
        begin
            rd_byte = s.snap[3'(a - srr_pkg::TIME_BASE)];
        end
        else if (a <= srr_pkg::MAP_LAST)
        begin
            rd_byte = s.alm[2'(a - srr_pkg::ALM_BASE)];
        end
        else
        begin
            rd_byte = srr_pkg::RST_ZERO;
        end
    endfunction

    // writes wait here; draining stalls on calendar update cycles
    srr_fifo #(
        .W(srr_pkg::FIFO_W),
        .D(srr_pkg::FIFO_D)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // next state of the whole block
    always_comb
    begin
        logic base;
        logic base_edge;
        logic [15:0] term;
        logic tick;
        logic [8:0] r;
        logic [7:0] hr;
        logic c_min;
        logic c_hr;
        logic c_day;
        logic c_mon;
        logic [3:0] carries;
        logic [2:0] set;
        logic run;
        logic sck_rise;
        logic sck_fall;
        logic [7:0] byte_in;
        logic [5:0] a;
        base = 1'b0;
        base_edge = 1'b0;
        term = 16'h0000;
        tick = 1'b0;
        r = 9'h000;
        hr = 8'h00;
        c_min = 1'b0;
        c_hr = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        carries = 4'h0;
        set = 3'b000;
        byte_in = 8'h00;
        a = 6'h00;
        sck_rise = sck_i && !s_ff.sck_q;
        sck_fall = !sck_i && s_ff.sck_q;
        fifo_in_valid = 1'b0;
        fifo_in_data = '0;
        nxt_s = s_ff;
        run = (s_ff.st == srr_pkg::ST_RUN);
        nxt_s.sck_q = sck_i;
        nxt_s.ss_q = ss_i;
        nxt_s.sys_q = system_power_sense_i;
        nxt_s.overrun = 1'b0;

        // time base select and divide to one second
        base = line_sel_i ? line_i : xtal_i;
        nxt_s.base_q = base;
        base_edge = base && !s_ff.base_q;
        term = line_sel_i ? (line_60hz_i ? srr_pkg::LINE_60
                                         : srr_pkg::LINE_50)
                          : 16'(XTAL_DIV);
        if (base_edge)
        begin
            if (s_ff.div >= term - 16'h0001)
            begin
                nxt_s.div = 16'h0000;
                tick = 1'b1;
            end
            else
            begin
                nxt_s.div = s_ff.div + 16'h0001;
            end
        end

        // buffered clock is half the time base, low when powered down
        if (!run || power_down_i)
        begin
            nxt_s.clk_out = 1'b0;
        end
        else if (base_edge)
        begin
            nxt_s.clk_out = !s_ff.clk_out;
        end

        // bcd calendar roll-over chain
        if (tick)
        begin
            r = bcd_inc(s_ff.tm[srr_pkg::R_SEC], srr_pkg::RST_ZERO,
                        srr_pkg::MAX_SEC);
            nxt_s.tm[srr_pkg::R_SEC] = r[7:0];
            c_min = r[8];
        end
        if (c_min)
        begin
            r = bcd_inc(s_ff.tm[srr_pkg::R_MIN], srr_pkg::RST_ZERO,
                        srr_pkg::MAX_SEC);
            nxt_s.tm[srr_pkg::R_MIN] = r[7:0];
            c_hr = r[8];
        end
        if (c_hr)
        begin
            hr = s_ff.tm[srr_pkg::R_HOUR];
            if (!hour_12_i)
            begin
                r = bcd_inc(hr, srr_pkg::RST_ZERO, srr_pkg::MAX_HR24);
                nxt_s.tm[srr_pkg::R_HOUR] = r[7:0];
                c_day = r[8];
            end
            else if (hr[4:0] == 5'h11)
            begin
                // eleven to twelve flips am/pm; pm to am is a new day
                nxt_s.tm[srr_pkg::R_HOUR] = {2'b00, !hr[srr_pkg::HR_PM_BIT],
                                             5'h12};
                c_day = hr[srr_pkg::HR_PM_BIT];
            end
            else
            begin
                r = bcd_inc({3'b000, hr[4:0]}, srr_pkg::RST_ONE,
                            srr_pkg::HR12_RST);
                nxt_s.tm[srr_pkg::R_HOUR] = {2'b00, hr[srr_pkg::HR_PM_BIT],
                                             r[4:0]};
            end
        end
        if (c_day)
        begin
            r = bcd_inc(s_ff.tm[srr_pkg::R_DOW], srr_pkg::RST_ONE,
                        srr_pkg::MAX_DOW);
            nxt_s.tm[srr_pkg::R_DOW] = r[7:0];
            r = bcd_inc(s_ff.tm[srr_pkg::R_DATE], srr_pkg::RST_ONE,
                        month_end(s_ff.tm[srr_pkg::R_MON],
                                  s_ff.tm[srr_pkg::R_YEAR]));
            nxt_s.tm[srr_pkg::R_DATE] = r[7:0];
            c_mon = r[8];
        end
        if (c_mon)
        begin
            r = bcd_inc(s_ff.tm[srr_pkg::R_MON], srr_pkg::RST_ONE,
                        srr_pkg::MAX_MON);
            nxt_s.tm[srr_pkg::R_MON] = r[7:0];
            if (r[8])
            begin
                r = bcd_inc(s_ff.tm[srr_pkg::R_YEAR], srr_pkg::RST_ZERO,
                            srr_pkg::MAX_YEAR);
                nxt_s.tm[srr_pkg::R_YEAR] = r[7:0];
            end
        end

        // event sources: alarm match, periodic rate, power loss
        if (tick && nxt_s.tm[2:0] == s_ff.alm)
        begin
            set[srr_pkg::F_ALM] = 1'b1;
        end
        carries = {c_day, c_hr, c_min, tick};
        set[srr_pkg::F_PER] = carries[per_rate_i];
        set[srr_pkg::F_PWR] = s_ff.sys_q && !system_power_sense_i;
        // set wins over a clear in the same cycle
        nxt_s.flags = (s_ff.flags & ~int_clear_i) | set;
        nxt_s.irq = |(nxt_s.flags & int_en_i);

        // power-down entry and exit
        case (s_ff.st)
            srr_pkg::ST_RUN:
            begin
                if (power_down_i)
                begin
                    nxt_s.st = srr_pkg::ST_PDN;
                end
            end
            srr_pkg::ST_PDN:
            begin
                if ((system_power_sense_i && !s_ff.sys_q) ||
                    (system_power_sense_i && |(set & int_en_i)))
                begin
                    nxt_s.st = srr_pkg::ST_RUN;
                end
            end
            default: nxt_s.st = srr_pkg::ST_RUN;
        endcase
        nxt_s.supply = (nxt_s.st == srr_pkg::ST_RUN);

        // watchdog fed by any slave-select change
        if (!wdog_en_i || !run || ss_i != s_ff.ss_q)
        begin
            nxt_s.wdog = 20'h00000;
        end
        else if (s_ff.wdog >= 20'(WDOG_CYC - 1))
        begin
            nxt_s.wdog = 20'h00000;
            nxt_s.hrst = 8'(HRST_CYC);
        end
        else
        begin
            nxt_s.wdog = s_ff.wdog + 20'h00001;
        end
        if (s_ff.hrst != 8'h00)
        begin
            nxt_s.hrst = s_ff.hrst - 8'h01;
        end
        nxt_s.hreset = (nxt_s.st == srr_pkg::ST_PDN) ||
                       (nxt_s.hrst != 8'h00);

        // serial port: sample on rise, shift out on fall
        if (!run || !ss_i)
        begin
            nxt_s.bitc = 3'h0;
            nxt_s.first = 1'b1;
            nxt_s.oe_n = 1'b1;
            nxt_s.miso = 1'b0;
        end
        else
        begin
            if (!s_ff.ss_q)
            begin
                nxt_s.snap = s_ff.tm;
            end
            if (sck_rise)
            begin
                byte_in = {s_ff.sh[6:0], mosi_i};
                nxt_s.sh = byte_in;
                nxt_s.bitc = s_ff.bitc + 3'h1;
                if (s_ff.bitc == 3'h7)
                begin
                    a = s_ff.first ? byte_in[5:0] : s_ff.addr + 6'h01;
                    nxt_s.first = 1'b0;
                    nxt_s.addr = a;
                    if (s_ff.first)
                    begin
                        nxt_s.wr = byte_in[srr_pkg::WR_BIT];
                    end
                    if (s_ff.first ? !byte_in[srr_pkg::WR_BIT] : !s_ff.wr)
                    begin
                        nxt_s.tx = rd_byte(s_ff, a);
                    end
                    if (!s_ff.first && s_ff.wr)
                    begin
                        nxt_s.addr = s_ff.addr + 6'h01;
                        fifo_in_valid = 1'b1;
                        fifo_in_data = {s_ff.addr, byte_in};
                        nxt_s.overrun = !fifo_in_ready;
                    end
                end
            end
            if (sck_fall && !s_ff.first && !s_ff.wr)
            begin
                nxt_s.oe_n = 1'b0;
                nxt_s.miso = s_ff.tx[7];
                nxt_s.tx = {s_ff.tx[6:0], 1'b0};
            end
        end

        // apply one buffered write when the calendar is idle
        fifo_out_ready = !tick;
        if (fifo_out_valid && !tick)
        begin
            a = fifo_out_data[13:8];
            if (a <= srr_pkg::RAM_LAST)
            begin
                nxt_s.ram[a[4:0]] = fifo_out_data[7:0];
            end
            else if (a < srr_pkg::ALM_BASE)
            begin
                nxt_s.tm[3'(a - srr_pkg::TIME_BASE)] =
                    fifo_out_data[7:0];
                nxt_s.first_up = 1'b0;
            end
            else if (a <= srr_pkg::MAP_LAST)
            begin
                nxt_s.alm[2'(a - srr_pkg::ALM_BASE)] = fifo_out_data[7:0];
            end
        end
    end

    // state register with reset values
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s_ff <= '0;
            s_ff.st <= srr_pkg::ST_RUN;
            s_ff.tm[srr_pkg::R_DOW] <= srr_pkg::RST_ONE;
            s_ff.tm[srr_pkg::R_DATE] <= srr_pkg::RST_ONE;
            s_ff.tm[srr_pkg::R_MON] <= srr_pkg::RST_ONE;
            s_ff.first <= 1'b1;
            s_ff.oe_n <= 1'b1;
            s_ff.supply <= 1'b1;
            s_ff.first_up <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign miso_o = s_ff.miso;
    assign miso_oe_n_o = s_ff.oe_n;
    assign irq_o = s_ff.irq;
    assign int_flags_o = s_ff.flags;
    assign host_reset_o = s_ff.hreset;
    assign supply_enable_o = s_ff.supply;
    assign buffered_clock_o = s_ff.clk_out;
    assign first_up_o = s_ff.first_up;
    assign wr_overrun_o = s_ff.overrun;
endmodule

// [test/srr_props.sv]
// port assertions for the clock/calendar top
// bound to every srr_top; sees only its ports
`timescale 1ns/1ps
module srr_props (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ss_i,
    input wire logic miso_oe_n_o,
    input wire logic [2:0] int_en_i,
    input wire logic [2:0] int_clear_i,
    input wire logic wdog_en_i,
    input wire logic power_down_i,
    input wire logic system_power_sense_i,
    input wire logic irq_o,
    input wire logic [2:0] int_flags_o,
    input wire logic host_reset_o,
    input wire logic supply_enable_o,
    input wire logic buffered_clock_o,
    input wire logic first_up_o,
    input wire logic wr_overrun_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // port deselected, power sense held low
    sequence ss_idle;
        !ss_i ##1 !ss_i;
    endsequence
    sequence sense_low;
        !system_power_sense_i [*3];
    endsequence
    // interrupt, power and port relations
    irq_match_a: assert property ($stable(int_en_i) |->
        irq_o == |(int_flags_o & int_en_i)) else $error("irq mismatch");
    flags_keep_a: assert property ((($past(int_flags_o) &
        ~$past(int_clear_i)) & ~int_flags_o) == 3'h0)
        else $error("flag lost");
    pdn_entry_a: assert property (supply_enable_o && power_down_i |=>
        host_reset_o && !supply_enable_o && !buffered_clock_o)
        else $error("no power-down");
    pdn_hold_a: assert property (sense_low ##0 !supply_enable_o |=>
        !supply_enable_o && host_reset_o) else $error("left power-down");
    pdn_exit_a: assert property (!supply_enable_o &&
        $rose(system_power_sense_i) |-> ##[1:3] supply_enable_o)
        else $error("no wake");
    pdn_quiet_a: assert property (!supply_enable_o &&
        !$past(supply_enable_o) |-> miso_oe_n_o) else $error("port live");
    ss_release_a: assert property (ss_idle |-> miso_oe_n_o)
        else $error("miso driven");
    first_up_a: assert property (!first_up_o |=> !first_up_o)
        else $error("first-up set");
    overrun_pulse_a: assert property (wr_overrun_o |=> !wr_overrun_o)
        else $error("long overrun");
    wdog_cause_a: assert property ($rose(host_reset_o) &&
        supply_enable_o |-> wdog_en_i) else $error("stray reset");
endmodule
bind srr_top srr_props props (
    .clock_i(clock_i), .rst_i(rst_i), .ss_i(ss_i),
    .miso_oe_n_o(miso_oe_n_o), .int_en_i(int_en_i),
    .int_clear_i(int_clear_i), .wdog_en_i(wdog_en_i),
    .power_down_i(power_down_i),
    .system_power_sense_i(system_power_sense_i), .irq_o(irq_o),
    .int_flags_o(int_flags_o), .host_reset_o(host_reset_o),
    .supply_enable_o(supply_enable_o),
    .buffered_clock_o(buffered_clock_o), .first_up_o(first_up_o),
    .wr_overrun_o(wr_overrun_o));

// [test/srr_host.sv]
// host serial master model: select, serial clock, data out
// assumes its tasks are called from one bench process
`timescale 1ns/1ps
module srr_host (
    input wire logic clock_i,
    input wire logic miso_i,
    output logic sck_o,
    output logic mosi_o,
    output logic ss_o,
    output logic [7:0] rx_o,
    output logic rx_stb_o
);
    int half = 4;
    // idle lines
    initial
    begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        ss_o = 1'b0;
        rx_o = 8'h00;
        rx_stb_o = 1'b0;
    end
    // wait cycles, moving only on falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // address byte then data bytes, msb first, sck idles low
    task automatic frame(input logic [7:0] adr, input logic [7:0] tx [$]);
        logic [7:0] b;
        ss_o = 1'b1;
        tick(half);
        for (int k = 0; k <= tx.size(); k++)
        begin
            b = (k == 0) ? adr : tx[k-1];
            for (int i = 7; i >= 0; i--)
            begin
                sck_o = 1'b0;
                mosi_o = b[i];
                tick(half);
                rx_o = {rx_o[6:0], miso_i};
                sck_o = 1'b1;
                tick(half);
            end
            rx_stb_o = (k > 0) && !adr[7];
            tick(1);
            rx_stb_o = 1'b0;
        end
        ss_o = 1'b0;
        mosi_o = ~mosi_o; // released line shows no stale bit
        tick(1);
        sck_o = 1'b0;
    endtask
    // alive signal: select toggled with no transfer
    task automatic poke();
        ss_o = 1'b1;
        tick(2);
        ss_o = 1'b0;
    endtask
endmodule

// [test/srr_top_tb_top.sv]
// self-checking bench for the clock/calendar top with host model
// assumes shortened divider, watchdog and reset-pulse lengths
`timescale 1ns/1ps
module srr_top_tb_top;
    logic clock_i, rst_i, xtal_i, power_down_i, sense, wdog_en_i;
    logic line, lsel, l60, h12;
    logic [2:0] int_en_i, int_clear_i, flags;
    logic [1:0] per_rate_i;
    logic sck, mosi, ss, miso_o, oe_n, irq, stb, hrst, sup, bclk, fup;
    logic [7:0] rx;
    logic [7:0] expq [$];
    logic [7:0] q [$];
    logic [7:0] a;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    srr_top #(.XTAL_DIV(4), .WDOG_CYC(50), .HRST_CYC(4)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .sck_i(sck), .mosi_i(mosi),
        .ss_i(ss), .miso_o(miso_o), .miso_oe_n_o(oe_n), .xtal_i(xtal_i),
        .line_i(line), .line_sel_i(lsel), .line_60hz_i(l60),
        .hour_12_i(h12), .int_en_i(int_en_i), .per_rate_i(per_rate_i),
        .int_clear_i(int_clear_i), .wdog_en_i(wdog_en_i),
        .power_down_i(power_down_i), .system_power_sense_i(sense),
        .irq_o(irq), .int_flags_o(flags), .host_reset_o(hrst),
        .supply_enable_o(sup), .buffered_clock_o(bclk),
        .first_up_o(fup), .wr_overrun_o());
    srr_host host (.clock_i(clock_i), .miso_i(miso_o ^ oe_n), .sck_o(sck),
        .mosi_o(mosi), .ss_o(ss), .rx_o(rx), .rx_stb_o(stb));
    // clock and cycle ceiling
    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            test_done();
        end
    end
    // read bytes are compared with the oldest note
    always @(posedge clock_i)
        if (stb === 1'b1)
            check(rx, expq.pop_front());
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // bursts at a random serial pace
    task automatic wr(input logic [7:0] ad, input logic [7:0] d [$]);
        host.half = 4 + 3 * ($urandom % 2);
        host.frame(ad | 8'h80, d);
        host.tick(4);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e [$]);
        host.half = 4 + 3 * ($urandom % 2);
        expq = {expq, e};
        host.frame(ad, e);
        host.tick(4);
    endtask
    // four crystal edges make one second
    task automatic tick_sec();
        repeat (4)
        begin
            xtal_i = 1'b1;
            host.tick(3);
            xtal_i = 1'b0;
            host.tick(3);
        end
        host.tick(3);
    endtask
    task automatic clr();
        int_clear_i = 3'h7;
        host.tick(1);
        int_clear_i = 3'h0;
        host.tick(1);
    endtask
    initial
    begin
        {rst_i, sense} = 2'b11;
        {xtal_i, power_down_i, wdog_en_i, line, lsel, l60, h12} = 7'h0;
        {int_en_i, int_clear_i, per_rate_i} = 8'h03;
        void'($urandom(41));
        repeat (5) @(posedge clock_i);
        host.tick(1);
        rst_i = 1'b0;
        check({fup, sup, hrst, irq}, 8'h0c);
        // random memory burst
        a = 8'(8 + $urandom % 20);
        for (int i = 0; i < 4; i++)
            q.push_back(8'($urandom));
        wr(a, q);
        rd(a, q);
        // day rollover, leap and plain year, alarm at midnight
        for (int j = 0; j < 2; j++)
        begin
            h12 = j[0];
            wr(8'h20, {8'h59, 8'h59, j ? 8'h31 : 8'h23, 8'h07, 8'h28, 8'h02,
                8'(j), 8'h00, 8'h00, j ? 8'h12 : 8'h00});
            check(8'(fup), 8'h00);
            tick_sec();
            rd(8'h20, {8'h00, 8'h00, j ? 8'h12 : 8'h00, 8'h01,
                j ? 8'h01 : 8'h29, j ? 8'h03 : 8'h02, 8'(j)});
            int_en_i = 3'h2;
            host.tick(2);
            check({flags, irq}, 8'h07);
            clr();
            check({flags, irq}, 8'h00);
        end
        // software power-down, port ignored, wake on sense rise
        power_down_i = 1'b1;
        host.tick(1);
        power_down_i = 1'b0;
        host.tick(2);
        check({hrst, sup, bclk}, 8'h04);
        wr(8'h05, {8'h5a});
        sense = 1'b0;
        host.tick(4);
        check({flags, sup}, 8'h08);
        sense = 1'b1;
        host.tick(4);
        check({hrst, sup}, 8'h01);
        rd(8'h05, {8'h00});
        // alarm wakes supply; burst runs into an unmapped place
        clr();
        int_en_i = 3'h1;
        wr(8'h27, {8'h01, 8'h00, 8'h12});
        power_down_i = 1'b1;
        host.tick(1);
        power_down_i = 1'b0;
        host.tick(2);
        check(8'(sup), 8'h00);
        tick_sec();
        check({sup, irq}, 8'h03);
        rd(8'h27, {8'h01, 8'h00, 8'h12, 8'h00});
        // watchdog kept alive, then starved
        int_en_i = 3'h0;
        wdog_en_i = 1'b1;
        repeat (4)
        begin
            host.poke();
            host.tick(20);
            check(8'(hrst), 8'h00);
        end
        for (int k = 0; k < 80 && hrst !== 1'b1; k++)
            host.tick(1);
        check(8'(hrst), 8'h01);
        test_done();
    end
endmodule
